// ### tpc_pkg.sv
// Shared constants, types and register map of the time processor host control block.
package tpc_pkg;

    localparam int TPC_NCH = 16;
    localparam int TPC_TBW = 16;
    localparam int TPC_AW = 12;
    localparam int TPC_DW = 32;
    localparam int TPC_REG_W = 16;
    localparam int TPC_CHW = 4;
    localparam logic [TPC_AW-1:0] TPC_SPACE = 12'h200;

    localparam logic [TPC_AW-1:0] TPC_OFF_CFG = 12'h000;
    localparam logic [TPC_AW-1:0] TPC_OFF_IEN = 12'h004;
    localparam logic [TPC_AW-1:0] TPC_OFF_IST = 12'h008;
    localparam logic [TPC_AW-1:0] TPC_OFF_TB1 = 12'h010;
    localparam logic [TPC_AW-1:0] TPC_OFF_TB2 = 12'h014;
    localparam logic [TPC_AW-1:0] TPC_OFF_FSEL = 12'h020;
    localparam logic [TPC_AW-1:0] TPC_OFF_HSEQ = 12'h030;
    localparam logic [TPC_AW-1:0] TPC_OFF_HSRQ = 12'h038;
    localparam logic [TPC_AW-1:0] TPC_OFF_PRI = 12'h040;

    localparam int TPC_CFG_STOP_BIT = 7;
    localparam int TPC_CFG_STF_BIT = 6;
    localparam int TPC_LVL_W = 3;
    localparam logic [TPC_LVL_W-1:0] TPC_LVL_RST = 3'h0;
    localparam logic [3:0] TPC_STRB_WORD = 4'hF;
    localparam int TPC_BYTE_CH = 8;

    localparam int TPC_FSEL_W = 4;
    localparam int TPC_HSEQ_W = 2;
    localparam int TPC_HSRQ_W = 2;
    localparam int TPC_PRI_W = 2;
    localparam logic [TPC_HSRQ_W-1:0] TPC_HSRQ_IDLE = 2'h0;

    localparam logic [TPC_FSEL_W-1:0] TPC_FN_PERIOD_PULSE_ACCUM = 4'hF;
    localparam logic [TPC_FSEL_W-1:0] TPC_FN_QUADRATURE_DECODE = 4'h6;
    localparam logic [TPC_FSEL_W-1:0] TPC_FN_PROG_TIME_ACCUM = 4'hF;
    localparam logic [TPC_FSEL_W-1:0] TPC_FN_HALL_DECODE = 4'h8;

    localparam int TPC_SLOTS = 7;
    localparam logic [2*TPC_SLOTS-1:0] TPC_SLOT_PATTERN = 14'h3B7B;

    typedef enum logic [1:0] {
        TPC_PRI_OFF = 2'b00,
        TPC_PRI_LOW = 2'b01,
        TPC_PRI_MID = 2'b10,
        TPC_PRI_HIGH = 2'b11
    } tpc_pri_t;

    typedef enum logic [1:0] {
        TPC_ST_RUN = 2'b00,
        TPC_ST_DRAIN = 2'b01,
        TPC_ST_HALT = 2'b10
    } tpc_stop_t;

    typedef struct packed {
        logic [TPC_NCH-1:0] flag_set;
        logic [TPC_NCH-1:0] svc_done;
        logic [TPC_NCH-1:0] link_req;
        logic idle;
        logic tb1_tick;
        logic tb2_tick;
    } tpc_evt_t;

    typedef struct packed {
        logic [TPC_NCH*TPC_FSEL_W-1:0] fsel;
        logic [TPC_NCH*TPC_HSEQ_W-1:0] hseq;
        logic [TPC_NCH*TPC_HSRQ_W-1:0] hsrq;
        logic [TPC_NCH*TPC_PRI_W-1:0] pri;
        logic [TPC_NCH-1:0] fn_valid;
        logic [TPC_NCH-1:0] irq_req;
        logic irq_any;
        logic eng_clk_en;
    } tpc_ctl_t;

endpackage

// ### tpc_time_base.sv
// Free-running time base counter that holds its value while halted.
`timescale 1ns/100ps
module tpc_time_base #(
    parameter int W = 16
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic tick,
    input wire logic hold,
    output logic [W-1:0] count
);
    logic [W-1:0] count_r;
    logic [W-1:0] count_nxt;

    if (W < 2) begin : g_chk
        $error("tpc_time_base: width too small");
    end

    always_comb begin
        count_nxt = count_r;
        if (tick && !hold) begin
            count_nxt = count_r + {{(W-1){1'b0}}, 1'b1};
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            count_r <= '0;
        end else begin
            count_r <= count_nxt;
        end
    end

    assign count = count_r;
endmodule // tpc_time_base

// ### tpc_slot_sched.sv
// Seven-slot priority scheduler that picks one requesting channel per slot.
`timescale 1ns/100ps
module tpc_slot_sched #(
    parameter int NCH = 16
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic halt,
    input wire logic [NCH*2-1:0] pri,
    input wire logic [NCH-1:0] req,
    output logic [$clog2(NCH)-1:0] grant_ch,
    output logic grant_valid,
    output logic [1:0] slot_level
);
    import tpc_pkg::*;

    localparam int CW = $clog2(NCH);
    logic [2:0] slot_r;
    logic [2:0] slot_nxt;
    logic [CW-1:0] ch_r;
    logic [CW-1:0] ch_nxt;
    logic vld_r;
    logic vld_nxt;
    logic [1:0] lvl_r;
    logic [1:0] lvl_nxt;
    logic [1:0] cur_lvl;

    if (NCH < 2) begin : g_chk
        $error("tpc_slot_sched: at least two channels needed");
    end

    always_comb begin
        cur_lvl = TPC_SLOT_PATTERN[slot_r*2 +: 2];
        slot_nxt = slot_r;
        ch_nxt = ch_r;
        vld_nxt = 1'b0;
        lvl_nxt = lvl_r;
        if (!halt) begin
            slot_nxt = (slot_r == 3'(TPC_SLOTS-1)) ? 3'h0 : slot_r + 3'h1;
            lvl_nxt = cur_lvl;
            for (int i = NCH-1; i >= 0; i--) begin
                if (req[i] && pri[i*2 +: 2] == cur_lvl && pri[i*2 +: 2] != TPC_PRI_OFF) begin
                    ch_nxt = CW'(i);
                    vld_nxt = 1'b1;
                end
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            slot_r <= 3'h0;
            ch_r <= '0;
            vld_r <= 1'b0;
            lvl_r <= TPC_PRI_OFF;
        end else begin
            slot_r <= slot_nxt;
            ch_r <= ch_nxt;
            vld_r <= vld_nxt;
            lvl_r <= lvl_nxt;
        end
    end

    assign grant_ch = ch_r;
    assign grant_valid = vld_r;
    assign slot_level = lvl_r;
endmodule // tpc_slot_sched

// ### tpc_host_ctrl.sv
// APB register bank for stop control, channel interrupts and channel control fields.
//
// The register offsets and the APB interface to the registers were chosen for this implementation.
`timescale 1ns/100ps
module tpc_host_ctrl #(
    parameter int NUM_CH = 16,
    parameter int UCODE_SET = 0
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [tpc_pkg::TPC_AW-1:0] paddr,
    input wire logic [tpc_pkg::TPC_DW-1:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [tpc_pkg::TPC_DW-1:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire tpc_pkg::tpc_evt_t evt,
    output tpc_pkg::tpc_ctl_t ctl,
    output logic [tpc_pkg::TPC_TBW-1:0] tb1_value,
    output logic [tpc_pkg::TPC_TBW-1:0] tb2_value,
    output logic [tpc_pkg::TPC_CHW-1:0] grant_ch,
    output logic grant_valid,
    output logic [1:0] grant_level
);
    import tpc_pkg::*;

    localparam int FW = NUM_CH * TPC_FSEL_W;
    localparam int QW = NUM_CH * TPC_HSEQ_W;
    localparam int RW = NUM_CH * TPC_HSRQ_W;
    localparam int PW = NUM_CH * TPC_PRI_W;

    if (NUM_CH != TPC_NCH) begin : g_chk_ch
        $error("tpc_host_ctrl: channel count must match the package");
    end
    if (UCODE_SET != 0 && UCODE_SET != 1) begin : g_chk_set
        $error("tpc_host_ctrl: microcode set must be 0 or 1");
    end

    logic stop_r;
    logic stop_nxt;
    logic [TPC_LVL_W-1:0] lvl_r;
    logic [TPC_LVL_W-1:0] lvl_nxt;
    logic [NUM_CH-1:0] ien_r;
    logic [NUM_CH-1:0] ien_nxt;
    logic [NUM_CH-1:0] ist_r;
    logic [NUM_CH-1:0] ist_nxt;
    logic [NUM_CH-1:0] seen_r;
    logic [NUM_CH-1:0] seen_nxt;
    logic [FW-1:0] fsel_r;
    logic [FW-1:0] fsel_nxt;
    logic [QW-1:0] hseq_r;
    logic [QW-1:0] hseq_nxt;
    logic [RW-1:0] hsrq_r;
    logic [RW-1:0] hsrq_nxt;
    logic [PW-1:0] pri_r;
    logic [PW-1:0] pri_nxt;
    logic [TPC_DW-1:0] prdata_r;
    logic [TPC_DW-1:0] prdata_nxt;
    tpc_stop_t state_r;
    tpc_stop_t state_nxt;

    logic setup;
    logic access;
    logic wr_ok;
    logic in_space;
    logic hit_ist;
    logic hit_fsel;
    logic hit_hseq;
    logic hit_hsrq;
    logic hit_pri;
    logic [1:0] idx4;
    logic idx2;
    logic [NUM_CH-1:0] ist_clr;
    logic [NUM_CH-1:0] fn_valid;
    logic [NUM_CH-1:0] irq_req;
    logic [NUM_CH-1:0] svc_req;
    logic [RW-1:0] hsrq_done_mask;
    logic stopped;
    logic tb_hold;

    // Address decode; each group of field registers holds 16 bits per word.
    always_comb begin
        setup = psel && !penable;
        access = psel && penable;
        in_space = paddr < TPC_SPACE;
        hit_ist = paddr == TPC_OFF_IST;
        hit_fsel = paddr[TPC_AW-1:4] == TPC_OFF_FSEL[TPC_AW-1:4] && paddr[1:0] == 2'h0;
        hit_hseq = paddr[TPC_AW-1:3] == TPC_OFF_HSEQ[TPC_AW-1:3] && paddr[1:0] == 2'h0;
        hit_hsrq = paddr[TPC_AW-1:3] == TPC_OFF_HSRQ[TPC_AW-1:3] && paddr[1:0] == 2'h0;
        hit_pri = paddr[TPC_AW-1:3] == TPC_OFF_PRI[TPC_AW-1:3] && paddr[1:0] == 2'h0;
        idx4 = paddr[3:2];
        idx2 = paddr[2];
    end

    // Zero-wait slave; partial writes outside the status register are refused.
    assign pready = 1'b1;
    assign pslverr = access && (!in_space || (pwrite && !hit_ist && pstrb != TPC_STRB_WORD));
    assign wr_ok = access && pwrite && !pslverr;

    // Per-channel status flag, clear qualification and service-request done.
    for (genvar c = 0; c < NUM_CH; c++) begin : g_ch
        assign ist_clr[c] = wr_ok && hit_ist && pstrb[c / TPC_BYTE_CH] && !pwdata[c] && seen_r[c];
        assign ist_nxt[c] = evt.flag_set[c] || (ist_r[c] && !ist_clr[c]);
        assign seen_nxt[c] = (setup && !pwrite && hit_ist) ? ist_r[c] : (seen_r[c] && !ist_clr[c]);
        assign irq_req[c] = ist_r[c] && ien_r[c] && (lvl_r != TPC_LVL_RST);
        assign hsrq_done_mask[c*TPC_HSRQ_W +: TPC_HSRQ_W] = {TPC_HSRQ_W{evt.svc_done[c]}};
        assign svc_req[c] = (hsrq_r[c*TPC_HSRQ_W +: TPC_HSRQ_W] != TPC_HSRQ_IDLE) || evt.link_req[c];
        if (UCODE_SET == 0) begin : g_seta
            assign fn_valid[c] = fsel_r[c*TPC_FSEL_W +: TPC_FSEL_W] >= TPC_FN_QUADRATURE_DECODE &&
                fsel_r[c*TPC_FSEL_W +: TPC_FSEL_W] <= TPC_FN_PERIOD_PULSE_ACCUM;
        end else begin : g_setb
            assign fn_valid[c] = fsel_r[c*TPC_FSEL_W +: TPC_FSEL_W] >= TPC_FN_HALL_DECODE &&
                fsel_r[c*TPC_FSEL_W +: TPC_FSEL_W] <= TPC_FN_PROG_TIME_ACCUM;
        end
    end

    // Software-written control fields.
    always_comb begin
        stop_nxt = stop_r;
        lvl_nxt = lvl_r;
        ien_nxt = ien_r;
        fsel_nxt = fsel_r;
        hseq_nxt = hseq_r;
        pri_nxt = pri_r;
        hsrq_nxt = hsrq_r & ~hsrq_done_mask;
        if (wr_ok) begin
            if (paddr == TPC_OFF_CFG) begin
                stop_nxt = pwdata[TPC_CFG_STOP_BIT];
                lvl_nxt = pwdata[TPC_LVL_W-1:0];
            end
            if (paddr == TPC_OFF_IEN) begin
                ien_nxt = pwdata[NUM_CH-1:0];
            end
            if (hit_fsel) begin
                fsel_nxt[idx4*TPC_REG_W +: TPC_REG_W] = pwdata[TPC_REG_W-1:0];
            end
            if (hit_hseq) begin
                hseq_nxt[idx2*TPC_REG_W +: TPC_REG_W] = pwdata[TPC_REG_W-1:0];
            end
            if (hit_hsrq) begin
                hsrq_nxt[idx2*TPC_REG_W +: TPC_REG_W] = pwdata[TPC_REG_W-1:0];
            end
            if (hit_pri) begin
                pri_nxt[idx2*TPC_REG_W +: TPC_REG_W] = pwdata[TPC_REG_W-1:0];
            end
        end
    end

    // Stop sequence: wait for the engine to go idle, then gate it and report stopped.
    always_comb begin
        state_nxt = state_r;
        case (state_r)
            TPC_ST_RUN: begin
                if (stop_r) begin
                    state_nxt = TPC_ST_DRAIN;
                end
            end
            TPC_ST_DRAIN: begin
                if (!stop_r) begin
                    state_nxt = TPC_ST_RUN;
                end else if (evt.idle) begin
                    state_nxt = TPC_ST_HALT;
                end
            end
            TPC_ST_HALT: begin
                if (!stop_r) begin
                    state_nxt = TPC_ST_RUN;
                end
            end
            default: begin
                state_nxt = TPC_ST_RUN;
            end
        endcase
    end

    assign stopped = state_r == TPC_ST_HALT;
    assign tb_hold = stop_r || state_r != TPC_ST_RUN;

    // Read data are captured in the setup cycle and shown in the access cycle.
    always_comb begin
        prdata_nxt = prdata_r;
        if (setup && !pwrite) begin
            prdata_nxt = '0;
            if (paddr == TPC_OFF_CFG) begin
                prdata_nxt[TPC_CFG_STOP_BIT] = stop_r;
                prdata_nxt[TPC_CFG_STF_BIT] = stopped;
                prdata_nxt[TPC_LVL_W-1:0] = lvl_r;
            end
            if (paddr == TPC_OFF_IEN) begin
                prdata_nxt[NUM_CH-1:0] = ien_r;
            end
            if (hit_ist) begin
                prdata_nxt[NUM_CH-1:0] = ist_r;
            end
            if (paddr == TPC_OFF_TB1) begin
                prdata_nxt[TPC_TBW-1:0] = tb1_value;
            end
            if (paddr == TPC_OFF_TB2) begin
                prdata_nxt[TPC_TBW-1:0] = tb2_value;
            end
            if (hit_fsel) begin
                prdata_nxt[TPC_REG_W-1:0] = fsel_r[idx4*TPC_REG_W +: TPC_REG_W];
            end
            if (hit_hseq) begin
                prdata_nxt[TPC_REG_W-1:0] = hseq_r[idx2*TPC_REG_W +: TPC_REG_W];
            end
            if (hit_hsrq) begin
                prdata_nxt[TPC_REG_W-1:0] = hsrq_r[idx2*TPC_REG_W +: TPC_REG_W];
            end
            if (hit_pri) begin
                prdata_nxt[TPC_REG_W-1:0] = pri_r[idx2*TPC_REG_W +: TPC_REG_W];
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            stop_r <= 1'b0;
            lvl_r <= TPC_LVL_RST;
            ien_r <= '0;
            ist_r <= '0;
            seen_r <= '0;
            fsel_r <= '0;
            hseq_r <= '0;
            hsrq_r <= '0;
            pri_r <= '0;
            prdata_r <= '0;
            state_r <= TPC_ST_RUN;
        end else begin
            stop_r <= stop_nxt;
            lvl_r <= lvl_nxt;
            ien_r <= ien_nxt;
            ist_r <= ist_nxt;
            seen_r <= seen_nxt;
            fsel_r <= fsel_nxt;
            hseq_r <= hseq_nxt;
            hsrq_r <= hsrq_nxt;
            pri_r <= pri_nxt;
            prdata_r <= prdata_nxt;
            state_r <= state_nxt;
        end
    end

    assign prdata = prdata_r;

    // Both time bases stop and keep their value while stopping or stopped.
    tpc_time_base #(
        .W(TPC_TBW)
    ) u_tb1 (
        .pclk(pclk),
        .presetn(presetn),
        .tick(evt.tb1_tick),
        .hold(tb_hold),
        .count(tb1_value)
    );

    tpc_time_base #(
        .W(TPC_TBW)
    ) u_tb2 (
        .pclk(pclk),
        .presetn(presetn),
        .tick(evt.tb2_tick),
        .hold(tb_hold),
        .count(tb2_value)
    );

    tpc_slot_sched #(
        .NCH(NUM_CH)
    ) u_sched (
        .pclk(pclk),
        .presetn(presetn),
        .halt(tb_hold),
        .pri(pri_r),
        .req(svc_req),
        .grant_ch(grant_ch),
        .grant_valid(grant_valid),
        .slot_level(grant_level)
    );

    // Channel fields and qualified requests towards the engine.
    always_comb begin
        ctl.fsel = fsel_r;
        ctl.hseq = hseq_r;
        ctl.hsrq = hsrq_r;
        ctl.pri = pri_r;
        ctl.fn_valid = fn_valid;
        ctl.irq_req = irq_req;
        ctl.irq_any = |irq_req;
        ctl.eng_clk_en = !stopped;
    end
endmodule // tpc_host_ctrl

// ### tpc_host_ctrl_monitor.sv
// Concurrent checks on the ports of the host control block.
`timescale 1ns/100ps
module tpc_host_ctrl_monitor #(
    parameter int UCODE_SET = 0
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [tpc_pkg::TPC_AW-1:0] paddr,
    input wire logic [3:0] pstrb,
    input wire logic [tpc_pkg::TPC_DW-1:0] prdata,
    input wire logic pslverr,
    input wire tpc_pkg::tpc_evt_t evt,
    input wire tpc_pkg::tpc_ctl_t ctl,
    input wire logic [tpc_pkg::TPC_TBW-1:0] tb1_value,
    input wire logic [tpc_pkg::TPC_TBW-1:0] tb2_value,
    input wire logic [tpc_pkg::TPC_CHW-1:0] grant_ch,
    input wire logic grant_valid,
    input wire logic [1:0] grant_level
);
    import tpc_pkg::*;
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    a_stop_hold: assert property (
        !ctl.eng_clk_en |=> $stable(tb1_value) && $stable(tb2_value))
        else $error("time base moved while halted");
    a_halt_sched: assert property (
        !ctl.eng_clk_en |=> $stable(grant_ch) && $stable(grant_valid))
        else $error("scheduler moved while halted");
    a_irq_cause: assert property (
        $rose(ctl.irq_any) |-> $past(|evt.flag_set || (psel && penable && pwrite)))
        else $error("interrupt request rose without cause");
    a_irq_any: assert property (
        ctl.irq_any == (|ctl.irq_req))
        else $error("summary request disagrees with channel requests");
    a_fn_valid: assert property (
        ctl.fn_valid[0] == (ctl.fsel[3:0] >= (UCODE_SET != 0 ? 4'h8 : 4'h6)))
        else $error("function code validity wrong");
    a_svc_done: assert property (
        evt.svc_done[0] && !(psel && penable && pwrite && paddr == TPC_OFF_HSRQ)
        |=> ctl.hsrq[1:0] == TPC_HSRQ_IDLE)
        else $error("service request not cleared");
    a_space_err: assert property (
        psel && penable && paddr >= TPC_SPACE |-> pslverr)
        else $error("access outside space not refused");
    a_unmap_zero: assert property (
        psel && !penable && !pwrite && paddr == 12'h100 |=> prdata == 32'h0)
        else $error("unmapped read not zero");
    a_byte_refuse: assert property (
        psel && penable && pwrite && pstrb != TPC_STRB_WORD && paddr != TPC_OFF_IST |-> pslverr)
        else $error("partial write accepted");
    a_ist_byte_ok: assert property (
        psel && penable && pwrite && paddr == TPC_OFF_IST |-> !pslverr)
        else $error("status write refused");
    a_grant_level: assert property (
        grant_valid && $stable(ctl.pri) |-> grant_level != TPC_PRI_OFF &&
        ctl.pri[grant_ch*TPC_PRI_W +: TPC_PRI_W] == grant_level)
        else $error("granted channel priority differs from slot level");
endmodule // tpc_host_ctrl_monitor

// ### tpc_eng_model.sv
// Behavioural model of the channel engine that drives the event inputs.
`timescale 1ns/100ps
module tpc_eng_model (
    input wire logic pclk,
    output tpc_pkg::tpc_evt_t evt
);
    import tpc_pkg::*;
    logic [TPC_NCH-1:0] fs;
    logic [TPC_NCH-1:0] sd;
    logic [TPC_NCH-1:0] lr;
    logic idl;
    logic t1;
    logic t2;
    assign evt = {fs, sd, lr, idl, t1, t2};
    initial begin
        fs = '0;
        sd = '0;
        lr = '0;
        idl = 1'b0;
        t1 = 1'b0;
        t2 = 1'b0;
    end
    task automatic link(input logic [15:0] v);
        lr <= v;
    endtask
    task automatic flag(input int c);
        fs <= 16'h0001 << c;
        @(posedge pclk);
        fs <= 16'h0000;
        @(posedge pclk);
    endtask
    task automatic done(input int c);
        sd <= 16'h0001 << c;
        @(posedge pclk);
        sd <= 16'h0000;
        @(posedge pclk);
    endtask
    task automatic ticks(input int n1, input int n2);
        for (int i = 0; i < 8; i++) begin
            t1 <= (i < n1);
            t2 <= (i < n2);
            @(posedge pclk);
        end
        t1 <= 1'b0;
        t2 <= 1'b0;
    endtask
    task automatic go_idle(input logic v);
        repeat ($urandom_range(1, 8)) @(posedge pclk);
        idl <= v;
    endtask
endmodule // tpc_eng_model

// ### testbench.sv
// Self-checking testbench for the host control block with its engine model.
`timescale 1ns/100ps
module testbench;
    import tpc_pkg::*;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, grant_valid;
    logic [TPC_AW-1:0] paddr;
    logic [TPC_DW-1:0] pwdata, prdata;
    logic [3:0] pstrb;
    tpc_evt_t evt;
    tpc_ctl_t ctl;
    logic [TPC_TBW-1:0] tb1_value, tb2_value;
    logic [TPC_CHW-1:0] grant_ch;
    logic [1:0] grant_level;
    logic [32:0] expq[$];
    int n_mismatch, checks_done;
    logic [15:0] v;
    int lv[4];
    localparam int TB_SET = 0;
    logic [11:0] rw_offs[8] = '{12'h020, 12'h024, 12'h028, 12'h02C, 12'h030, 12'h034, 12'h040, 12'h044};
    logic [11:0] rst_offs[8] = '{12'h000, 12'h004, 12'h008, 12'h010, 12'h014, 12'h038, 12'h03C, 12'h100};
    tpc_host_ctrl #(.UCODE_SET(TB_SET)) dut (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .evt(evt), .ctl(ctl), .tb1_value(tb1_value),
        .tb2_value(tb2_value), .grant_ch(grant_ch), .grant_valid(grant_valid), .grant_level(grant_level));
    tpc_eng_model eng (.pclk(pclk), .evt(evt));
    initial begin
        pclk = 1'b0;
        forever #4 pclk = ~pclk;
    end
    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic acc(input logic w, input logic [11:0] a, input logic [31:0] d, input logic [3:0] s,
        input logic e);
        expq.push_back({e, d});
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        pstrb <= s;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1) @(posedge pclk);
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask
    task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [3:0] s = 4'hF);
        acc(1'b1, a, d, s, 1'b0);
    endtask
    task automatic rd(input logic [11:0] a, input logic [31:0] d);
        acc(1'b0, a, d, 4'hF, 1'b0);
    endtask
    task automatic irq(input logic [15:0] exp);
        @(negedge pclk);
        chk("irq_req", ctl.irq_req, exp);
        chk("irq_any", ctl.irq_any, |exp);
        @(posedge pclk);
    endtask
    always @(posedge pclk) begin : scoreboard
        logic [32:0] e;
        if (presetn && psel && penable && pready) begin
            e = expq.pop_front();
            chk("pslverr", pslverr, e[32]);
            if (!pwrite) chk("prdata", prdata, e[31:0]);
        end
    end
    task automatic summarize();
        $display("checks %0d mismatches %0d", checks_done, n_mismatch);
        if (n_mismatch == 0 && checks_done > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    initial begin
        repeat (6000) @(posedge pclk);
        n_mismatch++;
        summarize();
    end
    initial begin
        {presetn, psel, penable, pwrite, paddr, pwdata, pstrb} = '0;
        n_mismatch = 0;
        checks_done = 0;
        void'($urandom(32'h471A));
        repeat (4) @(posedge pclk);
        presetn <= 1'b1;
        eng.link(16'($urandom));
        @(posedge pclk);
        foreach (rst_offs[i]) rd(rst_offs[i], 32'h0);
        acc(1'b0, TPC_SPACE, 32'h0, 4'hF, 1'b1);
        foreach (rw_offs[i]) begin
            v = 16'($urandom);
            wr(rw_offs[i], {16'($urandom), v});
            rd(rw_offs[i], {16'h0000, v});
        end
        for (int k = 0; k < 16; k++) begin
            wr(TPC_OFF_FSEL, 32'(k));
            wr(TPC_OFF_PRI, {16'h0000, {8{k[1:0]}}});
            @(negedge pclk);
            chk("fn_valid", ctl.fn_valid[0], k >= (TB_SET != 0 ? 8 : 6));
            chk("fsel", ctl.fsel[3:0], k[3:0]);
            chk("pri", ctl.pri[15:0], {8{k[1:0]}});
            @(posedge pclk);
        end
        wr(TPC_OFF_CFG, 32'h5);
        wr(TPC_OFF_IEN, 32'h8);
        eng.flag(3);
        eng.flag(4);
        irq(16'h0008);
        rd(TPC_OFF_IST, 32'h18);
        eng.flag(9);
        wr(TPC_OFF_IST, 32'h0, {2'($urandom), 2'h3});
        rd(TPC_OFF_IST, 32'h200);
        wr(TPC_OFF_IST, 32'h0, 4'h1);
        rd(TPC_OFF_IST, 32'h200);
        wr(TPC_OFF_IST, 32'h0, 4'h2);
        rd(TPC_OFF_IST, 32'h0);
        eng.flag(3);
        wr(TPC_OFF_CFG, 32'h0);
        irq(16'h0000);
        wr(TPC_OFF_CFG, 32'h5);
        irq(16'h0008);
        wr(TPC_OFF_IEN, 32'h0);
        irq(16'h0000);
        acc(1'b1, TPC_OFF_IEN, 32'hFF, 4'h3, 1'b1);
        rd(TPC_OFF_IEN, 32'h0);
        wr(TPC_OFF_HSRQ, 32'hE);
        rd(TPC_OFF_HSRQ, 32'hE);
        eng.done(0);
        rd(TPC_OFF_HSRQ, 32'hC);
        eng.done(1);
        rd(TPC_OFF_HSRQ, 32'h0);
        lv = '{default: 0};
        repeat (7) begin
            @(negedge pclk);
            lv[grant_level]++;
        end
        chk("high_slots", lv[3], 4);
        chk("mid_slots", lv[2], 2);
        chk("low_slots", lv[1], 1);
        @(posedge pclk);
        eng.ticks(5, 3);
        rd(TPC_OFF_TB1, 32'h5);
        rd(TPC_OFF_TB2, 32'h3);
        wr(TPC_OFF_CFG, 32'h80);
        eng.ticks(2, 4);
        rd(TPC_OFF_CFG, 32'h80);
        eng.go_idle(1'b1);
        repeat (2) @(posedge pclk);
        rd(TPC_OFF_CFG, 32'hC0);
        eng.ticks(3, 3);
        rd(TPC_OFF_TB1, 32'h5);
        rd(TPC_OFF_TB2, 32'h3);
        wr(TPC_OFF_CFG, 32'h0);
        eng.go_idle(1'b0);
        eng.ticks(1, 2);
        rd(TPC_OFF_TB1, 32'h6);
        rd(TPC_OFF_TB2, 32'h5);
        summarize();
    end
endmodule // testbench
bind tpc_host_ctrl tpc_host_ctrl_monitor #(.UCODE_SET(UCODE_SET)) mon (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pstrb(pstrb), .prdata(prdata),
    .pslverr(pslverr), .evt(evt), .ctl(ctl), .tb1_value(tb1_value), .tb2_value(tb2_value),
    .grant_ch(grant_ch), .grant_valid(grant_valid), .grant_level(grant_level));
